// [tsm_consts.svh]
// Constants of the transmit time slot to channel map block.
// Assumes inclusion by bare name; definitions only.
//
// Operation
// - Keep 8192 slot/group map entries and 512 group pointer entries.
// - Walk only entries between a port's start and end pointers.
// - Group slot: read group start, length, current, then group map entry.
// - Hold one start/end pointer pair for each of 32 ports.
// - Direct slot takes its channel from entry bits 13:3, up to 2047.
// - Entry bit 17 selects direct channel or group extraction.
// - With extraction, only lower 9 bits of the field form the group.
// - Bit 2 enables the slot, meaningful only without extraction.
// - Bit 1 selects full 8 bits or per-channel bit mask.
// - Bit 0 marks the channel's final slot.
// - Group entry: channel 13:3, enable 2, mask enable 1, final 0.
// - All ports share one slot map and one group map, divided by their pointers.
// - Unchannelized port uses only the entry at its start pointer.
`ifndef TSM_CONSTS_SVH
`define TSM_CONSTS_SVH

`define TSM_SLOT_DEPTH 8192
`define TSM_GRP_DEPTH 512
`define TSM_PORTS 32
`define TSM_EXT_BIT 17
`define TSM_CHAN_HI 13
`define TSM_CHAN_LO 3
`define TSM_GREF_HI 11
`define TSM_EN_BIT 2
`define TSM_MASK_BIT 1
`define TSM_FINAL_BIT 0
`define TSM_PEND_HI 28
`define TSM_PEND_LO 16
`define TSM_PSTART_HI 12
`define TSM_PSTART_LO 0
`define TSM_GSTART_HI 18
`define TSM_GSTART_LO 6
`define TSM_GLEN_HI 5
`define TSM_GLEN_LO 0
// Region select on adr_i[16:15], word index on adr_i[14:2]
`define TSM_RGN_SLOT 2'h0
`define TSM_RGN_GMAP 2'h1
`define TSM_RGN_GPTR 2'h2
`define TSM_RGN_CTRL 2'h3
`define TSM_IDX_UNCHAN 13'h0020
`define TSM_IDX_STATUS 13'h0021
`define TSM_BUF_FULL 2'h2

`endif

// [tsm_framer_model.sv]
// Far side model: framers asking for slot records and the per-channel consumer.
// Assumes the slot request handshake and the record buffer of tsm_map on clk_i.
`timescale 1ns/1ps

module tsm_framer_model (
   input wire logic clk_i,                      // 100 MHz clock
   input wire logic rst_i,                      // Synchronous reset
   input wire logic go_i,                       // Issue one request
   input wire logic [4:0] port_i,               // Port for that request
   input wire logic stall_i,                    // Consumer refuses records
   output logic req_valid_o,                    // Slot wanted
   output logic [4:0] req_port_o,               // Port of slot
   input wire logic req_ready_i,                // Request taken
   input wire logic out_valid_i,                // Record available
   input wire tsm_pkg::tsm_slot_out_type out_rec_i, // Slot record
   output logic out_ready_o                     // Record taken
);
   import tsm_pkg::*;

   tsm_slot_out_type got_q[$];

   // Port lines flip when released so a stale value never looks valid
   always @(posedge clk_i) begin
      if (rst_i) begin
         req_valid_o <= 1'b0;
         req_port_o <= 5'h00;
      end else if (req_valid_o && req_ready_i) begin
         req_valid_o <= 1'b0;
         req_port_o <= ~req_port_o;
      end else if (go_i && !req_valid_o) begin
         req_valid_o <= 1'b1;
         req_port_o <= port_i;
      end
      if (!rst_i && out_valid_i && out_ready_o) begin
         got_q.push_back(out_rec_i);
      end
   end

   assign out_ready_o = !stall_i;
endmodule

// [tsm_map.sv]
// Transmit time slot map: turns each port's slot request into a channel record.
// Assumes a classic Wishbone master for configuration and framers on clk_i.
`timescale 1ns/1ps
`include "tsm_consts.svh"

module tsm_map (
   input wire logic clk_i,                         // 100 MHz clock
   input wire logic rst_i,                         // Synchronous reset
   input wire logic wb_cyc_i,                      // Wishbone cycle
   input wire logic wb_stb_i,                      // Wishbone strobe
   input wire logic wb_we_i,                       // Wishbone write
   input wire logic [16:0] wb_adr_i,               // Byte address
   input wire logic [3:0] wb_sel_i,                // Byte enables
   input wire logic [31:0] wb_dat_i,               // Write data
   output logic [31:0] wb_dat_o,                   // Read data
   output logic wb_ack_o,                          // Acknowledge
   input wire logic req_valid_i,                   // Next slot wanted
   input wire logic [4:0] req_port_i,              // Port of that slot
   output logic req_ready_o,                       // Request taken
   output logic out_valid_o,                       // Record available
   output tsm_pkg::tsm_slot_out_type out_rec_o,    // Slot record
   input wire logic out_ready_i                    // Consumer takes record
);
   import tsm_pkg::*;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [17:0] slot_mem [`TSM_SLOT_DEPTH];
   logic [13:0] gmap_mem [`TSM_SLOT_DEPTH];
   logic [18:0] gptr_mem [`TSM_GRP_DEPTH];
   logic [5:0] gcur_q [`TSM_GRP_DEPTH];
   logic [12:0] pstart_q [`TSM_PORTS];
   logic [12:0] pend_q [`TSM_PORTS];
   logic [12:0] pcur_q [`TSM_PORTS];
   logic [31:0] unchan_q;
   logic [15:0] done_cnt_q;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic ack_q;
   logic [31:0] rdat_q;
   wire bus_req = wb_cyc_i & wb_stb_i;
   wire [1:0] rgn = wb_adr_i[16:15];
   wire [12:0] idx = wb_adr_i[14:2];
   wire full_word = (wb_sel_i == 4'hF);
   // Writes land at the edge where the master sees ack
   wire bus_wr = bus_req & ack_q & wb_we_i & full_word;
   wire wr_slot = bus_wr & (rgn == `TSM_RGN_SLOT);
   wire wr_gmap = bus_wr & (rgn == `TSM_RGN_GMAP);
   wire wr_gptr = bus_wr & (rgn == `TSM_RGN_GPTR) & (idx[12:9] == 4'h0);
   wire wr_pptr = bus_wr & (rgn == `TSM_RGN_CTRL) & (idx[12:5] == 8'h00);
   wire wr_unch = bus_wr & (rgn == `TSM_RGN_CTRL) & (idx == `TSM_IDX_UNCHAN);
   wire [8:0] gidx = idx[8:0];
   wire [4:0] pidx = idx[4:0];

   tsm_state_type st_q;
   logic [1:0] cnt_q;
   wire [31:0] status_word = {14'h0000, cnt_q, st_q[1:0], done_cnt_q[13:0]};
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (rgn)
         `TSM_RGN_SLOT: rd_mux = {14'h0000, slot_mem[idx]};
         `TSM_RGN_GMAP: rd_mux = {18'h00000, gmap_mem[idx]};
         `TSM_RGN_GPTR: begin
            if (idx[12:9] == 4'h0) begin
               rd_mux = {13'h0000, gptr_mem[gidx]};
            end
         end
         default: begin
            if (idx[12:5] == 8'h00) begin
               rd_mux = {3'h0, pend_q[pidx], 3'h0, pstart_q[pidx]};
            end else if (idx == `TSM_IDX_UNCHAN) begin
               rd_mux = unchan_q;
            end else if (idx == `TSM_IDX_STATUS) begin
               rd_mux = status_word;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req & ~ack_q;
         rdat_q <= rd_mux;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   always_ff @(posedge clk_i) begin
      if (wr_slot) begin
         slot_mem[idx] <= wb_dat_i[17:0];
      end
      if (wr_gmap) begin
         gmap_mem[idx] <= wb_dat_i[13:0];
      end
      if (wr_gptr) begin
         gptr_mem[gidx] <= wb_dat_i[18:0];
      end
   end

   // ----------------------------------------
   // Slot walk
   // ----------------------------------------
   logic [4:0] port_q;
   logic [8:0] grp_q;
   tsm_slot_out_type rec_q;
   wire buf_ready = (cnt_q != `TSM_BUF_FULL);
   wire take = req_valid_i & (st_q == TSM_IDLE);
   assign req_ready_o = (st_q == TSM_IDLE);

   wire [12:0] cur_sel = pcur_q[port_q];
   wire [12:0] start_sel = pstart_q[port_q];
   wire [12:0] end_sel = pend_q[port_q];
   wire unc_sel = unchan_q[port_q];
   wire [17:0] slot_rd = slot_mem[cur_sel];
   wire is_ext = slot_rd[`TSM_EXT_BIT];
   // Out of window (after a pointer change) snaps back into range
   wire out_rng = (cur_sel < start_sel) | (cur_sel >= end_sel);
   wire [12:0] cur_inc = cur_sel + 13'h0001;
   wire [12:0] cur_nx = (unc_sel | out_rng) ? start_sel : cur_inc;
   wire pptr_hit = wr_pptr & (pidx == port_q);

   wire [18:0] gptr_rd = gptr_mem[grp_q];
   wire [12:0] gstart = gptr_rd[`TSM_GSTART_HI:`TSM_GSTART_LO];
   wire [5:0] glen = gptr_rd[`TSM_GLEN_HI:`TSM_GLEN_LO];
   wire [5:0] gcur = gcur_q[grp_q];
   wire [12:0] gaddr = gstart + {7'h00, gcur};
   wire [13:0] gent = gmap_mem[gaddr];
   // Zero-based length: wrap after offset equals length
   wire [5:0] gcur_nx = (gcur >= glen) ? 6'h00 : gcur + 6'h01;
   wire gptr_hit = wr_gptr & (gidx == grp_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= TSM_IDLE;
         port_q <= 5'h00;
         grp_q <= 9'h000;
         rec_q <= '0;
      end else begin
         case (st_q)
            TSM_IDLE: begin
               if (take) begin
                  port_q <= req_port_i;
                  st_q <= TSM_SLOT;
               end
            end
            TSM_SLOT: begin
               if (is_ext) begin
                  grp_q <= slot_rd[`TSM_GREF_HI:`TSM_CHAN_LO];
                  st_q <= TSM_GROUP;
               end else begin
                  rec_q.port <= port_q;
                  rec_q.chan <= slot_rd[`TSM_CHAN_HI:`TSM_CHAN_LO];
                  rec_q.slot_en <= slot_rd[`TSM_EN_BIT];
                  rec_q.mask_en <= slot_rd[`TSM_MASK_BIT];
                  rec_q.final_slot <= slot_rd[`TSM_FINAL_BIT];
                  st_q <= TSM_PUSH;
               end
            end
            TSM_GROUP: begin
               rec_q.port <= port_q;
               rec_q.chan <= gent[`TSM_CHAN_HI:`TSM_CHAN_LO];
               rec_q.slot_en <= gent[`TSM_EN_BIT];
               rec_q.mask_en <= gent[`TSM_MASK_BIT];
               rec_q.final_slot <= gent[`TSM_FINAL_BIT];
               st_q <= TSM_PUSH;
            end
            TSM_PUSH: begin
               if (buf_ready) begin
                  st_q <= TSM_IDLE;
               end
            end
            default: st_q <= TSM_IDLE;
         endcase
      end
   end

   // Cursors: software pointer writes restart the walk, and win over the walk
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int p = 0; p < `TSM_PORTS; p++) begin
            pstart_q[p] <= 13'h0000;
            pend_q[p] <= 13'h0000;
            pcur_q[p] <= 13'h0000;
         end
         for (int g = 0; g < `TSM_GRP_DEPTH; g++) begin
            gcur_q[g] <= 6'h00;
         end
         unchan_q <= 32'h0000_0000;
      end else begin
         if (st_q == TSM_SLOT && !pptr_hit) begin
            pcur_q[port_q] <= cur_nx;
         end
         if (st_q == TSM_GROUP && !gptr_hit) begin
            gcur_q[grp_q] <= gcur_nx;
         end
         if (wr_pptr) begin
            pstart_q[pidx] <= wb_dat_i[`TSM_PSTART_HI:`TSM_PSTART_LO];
            pend_q[pidx] <= wb_dat_i[`TSM_PEND_HI:`TSM_PEND_LO];
            pcur_q[pidx] <= wb_dat_i[`TSM_PSTART_HI:`TSM_PSTART_LO];
         end
         if (wr_gptr) begin
            gcur_q[gidx] <= 6'h00;
         end
         if (wr_unch) begin
            unchan_q <= wb_dat_i;
         end
      end
   end

   // ----------------------------------------
   // Two-entry output buffer
   // ----------------------------------------
   tsm_slot_out_type b0_q;
   tsm_slot_out_type b1_q;
   wire push = (st_q == TSM_PUSH) & buf_ready;
   wire pop = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 2'h0;
         b0_q <= '0;
         b1_q <= '0;
         done_cnt_q <= 16'h0000;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (cnt_q == 2'h0) begin
                  b0_q <= rec_q;
               end else begin
                  b1_q <= rec_q;
               end
               cnt_q <= cnt_q + 2'h1;
            end
            2'b01: begin
               b0_q <= b1_q;
               cnt_q <= cnt_q - 2'h1;
            end
            2'b11: begin
               b0_q <= rec_q;
            end
            default: cnt_q <= cnt_q;
         endcase
         if (push) begin
            done_cnt_q <= done_cnt_q + 16'h0001;
         end
      end
   end

   assign out_valid_o = (cnt_q != 2'h0);
   assign out_rec_o = b0_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   AST_ACK_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack not given one cycle after request");

   AST_EXT_GROUP: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && is_ext) |=> (st_q == TSM_GROUP))
      else $error("extraction entry did not go to group lookup");

   AST_GROUP_REF: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && is_ext) |=> (grp_q == $past(slot_rd[`TSM_GREF_HI:`TSM_CHAN_LO])))
      else $error("group reference not lower nine bits of field");

   AST_DIRECT_CHAN: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && !is_ext)
      |=> (st_q == TSM_PUSH)
          && (rec_q.chan == $past(slot_rd[`TSM_CHAN_HI:`TSM_CHAN_LO]))
          && (rec_q.slot_en == $past(slot_rd[`TSM_EN_BIT])))
      else $error("direct channel record wrong");

   AST_UNCHAN_START: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && unc_sel && !pptr_hit) |=> (pcur_q[port_q] == pstart_q[port_q]))
      else $error("unchannelized port left its start entry");

   AST_WRAP_START: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && cur_sel == end_sel && !pptr_hit)
      |=> (pcur_q[port_q] == $past(start_sel)))
      else $error("walk did not return to start after end entry");

   AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && !unc_sel && !out_rng && !pptr_hit)
      |=> (pcur_q[port_q] == $past(cur_sel) + 13'h0001))
      else $error("walk did not advance by one entry");

   AST_BUF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_rec_o)))
      else $error("stalled record changed or was lost");

   AST_FLOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_IDLE && req_valid_i) |=> (st_q == TSM_SLOT) ##1 (st_q != TSM_SLOT))
      else $error("request not walked through slot lookup");

   AST_DIRECT_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_SLOT && !is_ext)
      |=> (rec_q.port == $past(port_q))
          && (rec_q.mask_en == $past(slot_rd[`TSM_MASK_BIT]))
          && (rec_q.final_slot == $past(slot_rd[`TSM_FINAL_BIT])))
      else $error("direct record flags or port wrong");

   AST_GROUP_REC: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_GROUP)
      |=> (st_q == TSM_PUSH) && (rec_q.port == $past(port_q))
          && (rec_q.chan == $past(gent[`TSM_CHAN_HI:`TSM_CHAN_LO]))
          && (rec_q.slot_en == $past(gent[`TSM_EN_BIT]))
          && (rec_q.mask_en == $past(gent[`TSM_MASK_BIT]))
          && (rec_q.final_slot == $past(gent[`TSM_FINAL_BIT])))
      else $error("group record wrong");

   AST_GRP_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_GROUP && !gptr_hit && gcur < glen)
      |=> (gcur_q[grp_q] == $past(gcur) + 6'h01))
      else $error("group offset did not advance");

   AST_GRP_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_GROUP && !gptr_hit && gcur >= glen)
      |=> (gcur_q[grp_q] == 6'h00))
      else $error("group offset did not wrap to start");

   AST_PPTR_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_pptr
      |=> (pstart_q[$past(pidx)] == $past(wb_dat_i[`TSM_PSTART_HI:`TSM_PSTART_LO]))
          && (pend_q[$past(pidx)] == $past(wb_dat_i[`TSM_PEND_HI:`TSM_PEND_LO]))
          && (pcur_q[$past(pidx)] == $past(wb_dat_i[`TSM_PSTART_HI:`TSM_PSTART_LO])))
      else $error("port pointer write not taken");

   AST_BUF_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
      (cnt_q <= `TSM_BUF_FULL))
      else $error("record buffer count above two");

   AST_STALL_PUSH: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == TSM_PUSH && !buf_ready) |=> (st_q == TSM_PUSH) && $stable(rec_q))
      else $error("record left engine while buffer was full");

endmodule

// [tsm_map_test.sv]
// Testbench of tsm_map: Wishbone set-up, slot requests and record checks.
// Assumes tsm_framer_model stands in for framers and the channel consumer.
`timescale 1ns/1ps

module tsm_map_test;
   import tsm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, go = 1'b0, stall = 1'b0;
   logic [16:0] wb_adr = 17'h00000;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
   logic wb_ack_o, req_valid, req_ready_o, out_valid_o, out_ready;
   logic [4:0] port = 5'h00, req_port;
   tsm_slot_out_type out_rec_o, r;
   int num_errors = 0;
   int n_checks = 0;

   always #5 clk_i = ~clk_i;

   tsm_map tsm_map_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid),
      .req_port_i(req_port), .req_ready_o(req_ready_o), .out_valid_o(out_valid_o),
      .out_rec_o(out_rec_o), .out_ready_i(out_ready));

   tsm_framer_model tsm_framer_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
      .port_i(port), .stall_i(stall), .req_valid_o(req_valid), .req_port_o(req_port),
      .req_ready_i(req_ready_o), .out_valid_i(out_valid_o), .out_rec_i(out_rec_o),
      .out_ready_o(out_ready));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic results();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Hung waits count as a mismatch and end the run
   task automatic give_up();
      num_errors++;
      results();
   endtask

   task automatic wb(input logic we, input logic [16:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= s;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [16:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [16:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      check(q & m, e);
   endtask

   task automatic ask(input logic [4:0] p);
      int n;
      go <= 1'b1;
      port <= p;
      @(posedge clk_i);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (req_valid !== 1'b0 && n < 50);
      if (n >= 50) give_up();
   endtask

   task automatic pop(input logic [4:0] p, input logic [10:0] c, input logic [2:0] b);
      int n;
      n = 0;
      while (tsm_framer_model_inst.got_q.size() == 0 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) give_up();
      r = tsm_framer_model_inst.got_q.pop_front();
      check({13'h0, r}, {13'h0, p, c, b});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({30'h0, out_valid_o, req_ready_o}, 32'h1);
      rd(17'h18084, 32'h0003FFFF, 32'h0);
      // Direct slots of port 3, channel 7FF also used by port 5's group
      wr(17'h1800C, 32'h000C000A);
      wr(17'h00028, 32'h0000091C);
      wb(1'b1, 17'h00028, 32'h0, 4'h3);    // Partial write dropped
      wr(17'h0002C, 32'h00003FFF);
      wr(17'h00030, 32'h00000003);
      rd(17'h00028, 32'hFFFFFFFF, 32'h0000091C);
      rd(17'h1800C, 32'hFFFFFFFF, 32'h000C000A);
      rd(17'h18100, 32'hFFFFFFFF, 32'h0);
      // Unchannelized port 7 keeps its start entry
      wr(17'h1801C, 32'h0028001E);
      wr(17'h00078, 32'h000002AC);
      wr(17'h18080, 32'h00000080);
      // Group slot of time-slot-bus port 5, upper field bits set to be ignored
      wr(17'h18014, 32'h00140014);
      wr(17'h00050, 32'h00023828);
      wr(17'h10414, 32'h00001901);
      wr(17'h08190, 32'h00003FFD);
      wr(17'h08194, 32'h0000002A);
      rd(17'h10414, 32'hFFFFFFFF, 32'h00001901);
      rd(17'h08194, 32'hFFFFFFFF, 32'h0000002A);
      rd(17'h18080, 32'hFFFFFFFF, 32'h00000080);
      ask(5'd3);
      pop(5'd3, 11'h123, 3'b100);
      ask(5'd7);
      pop(5'd7, 11'h055, 3'b100);
      ask(5'd3);
      pop(5'd3, 11'h7FF, 3'b111);
      ask(5'd3);
      pop(5'd3, 11'h000, 3'b011);
      ask(5'd3);
      pop(5'd3, 11'h123, 3'b100);
      ask(5'd5);
      pop(5'd5, 11'h7FF, 3'b101);
      ask(5'd5);
      pop(5'd5, 11'h005, 3'b010);
      ask(5'd5);
      pop(5'd5, 11'h7FF, 3'b101);
      ask(5'd3);
      pop(5'd3, 11'h7FF, 3'b111);
      // Stalled consumer: buffer holds two, third waits in the engine
      stall <= 1'b1;
      ask(5'd7);
      ask(5'd7);
      ask(5'd7);
      repeat (5) @(posedge clk_i);
      check({30'h0, out_valid_o, req_ready_o}, 32'h2);
      // Two buffered, engine parked in push state, eleven records produced
      rd(17'h18084, 32'h0003FFFF, 32'h0002800B);
      stall <= 1'b0;
      repeat (3) pop(5'd7, 11'h055, 3'b100);
      ask(5'd5);
      pop(5'd5, 11'h005, 3'b010);
      results();
   end

   initial begin
      #200000;
      give_up();
   end
endmodule

// [tsm_pkg.sv]
// Types of the transmit time slot to channel map block.
// Assumes tsm_consts.svh holds all numeric constants.
package tsm_pkg;

   typedef enum logic [1:0] {
      TSM_IDLE = 2'h0,
      TSM_SLOT = 2'h1,
      TSM_GROUP = 2'h3,
      TSM_PUSH = 2'h2
   } tsm_state_type;

   typedef struct packed {
      logic [4:0] port;
      logic [10:0] chan;
      logic slot_en;
      logic mask_en;
      logic final_slot;
   } tsm_slot_out_type;

endpackage
